// File: spsrg_defines.svh
// register offsets, field positions and reset values of the sample rate generator
`ifndef SPSRG_DEFINES_SVH
`define SPSRG_DEFINES_SVH

`define SPSRG_ADDR_W 8
`define SPSRG_OFS_CTRL 8'h00
`define SPSRG_OFS_PIN 8'h04
`define SPSRG_OFS_GEN1 8'h08
`define SPSRG_OFS_GEN2 8'h0C
`define SPSRG_OFS_STAT 8'h10

// port control word
`define SPSRG_CTRL_W 5
`define SPSRG_CTRL_GEN_RUN 0
`define SPSRG_CTRL_FRM_RUN 1
`define SPSRG_CTRL_LOOP 2
`define SPSRG_CTRL_STOP_LO 3
`define SPSRG_CTRL_STOP_HI 4
`define SPSRG_CTRL_RESET 5'h00

// pin control word
`define SPSRG_PIN_W 12
`define SPSRG_PIN_RX_POL 0
`define SPSRG_PIN_TX_POL 1
`define SPSRG_PIN_SRC_HIGH 7
`define SPSRG_PIN_RX_DIR 8
`define SPSRG_PIN_TX_DIR 9
`define SPSRG_PIN_RX_FSRC 10
`define SPSRG_PIN_TX_FSRC 11
`define SPSRG_PIN_RESET 12'h000

// generator control one
`define SPSRG_GEN1_DIV_LO 0
`define SPSRG_GEN1_DIV_HI 7
`define SPSRG_GEN1_WID_LO 8
`define SPSRG_GEN1_WID_HI 15
`define SPSRG_GEN1_RESET 16'h0001

// generator control two
`define SPSRG_GEN2_PER_LO 0
`define SPSRG_GEN2_PER_HI 11
`define SPSRG_GEN2_FGSEL 12
`define SPSRG_GEN2_SRC_LOW 13
`define SPSRG_GEN2_RESYNC 15
`define SPSRG_GEN2_RESET 16'h2000

`endif

// File: spsrg_pkg.sv
// types shared by the sample rate generator modules
package spsrg_pkg;
	typedef enum logic [1:0] {GEN_HOLD, GEN_HIGH, GEN_LOW} spsrg_gen_state_type;
	typedef enum logic [1:0] {SRC_NONE, SRC_INT, SRC_RXPIN, SRC_TXPIN} spsrg_src_type;
	typedef logic [7:0] spsrg_byte_type;
endpackage : spsrg_pkg

// File: spsrg_sync_if.sv
// one synchronised pin: raw level in, filtered level and edge pulses out
`timescale 1ns/10ps
interface spsrg_sync_if;
	logic raw;
	logic level;
	logic rise;
	logic fall;
	modport sync (input raw, output level, output rise, output fall);
	modport user (output raw, input level, input rise, input fall);
endinterface : spsrg_sync_if

// File: spsrg_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module spsrg_pin_sync (
	input wire logic clock,
	input wire logic reset_n,
	spsrg_sync_if.sync port
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;
	logic rise_q;
	logic rise_d;
	logic fall_q;
	logic fall_d;

	always_comb begin
		stage_d = {stage_q[1:0], port.raw};
		level_d = level_q;
		// a change counts only once the last two stages agree
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
		rise_d = level_d & ~level_q;
		fall_d = ~level_d & level_q;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	assign port.level = level_q;
	assign port.rise = rise_q;
	assign port.fall = fall_q;
endmodule : spsrg_pin_sync

// File: spsrg_top.sv
// sample rate generator: source select, bit clock divider, frame pulse, pin steering
`timescale 1ns/10ps
`include "spsrg_defines.svh"
module spsrg_top (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SPSRG_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxClockPinIn,
	output logic rxClockPinOut,
	output logic rxClockPinOe,
	input wire logic txClockPinIn,
	output logic txClockPinOut,
	output logic txClockPinOe,
	input wire logic rxFrameSyncPinIn,
	input wire logic txFrameSyncPinIn,
	output logic txFrameSyncPinOut,
	output logic txFrameSyncPinOe,
	input wire logic txCopyStrobe,
	output logic genBitClock,
	output logic genFramePulse,
	output logic rxClockInternal,
	output logic txClockInternal,
	output logic rxFrameInternal,
	output logic txFrameInternal,
	output logic spiMaster
);
	////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	function automatic logic isMapped(input logic [`SPSRG_ADDR_W-1:0] addr);
		isMapped = (addr == `SPSRG_OFS_CTRL) || (addr == `SPSRG_OFS_PIN)
			|| (addr == `SPSRG_OFS_GEN1) || (addr == `SPSRG_OFS_GEN2)
			|| (addr == `SPSRG_OFS_STAT);
	endfunction : isMapped

	function automatic spsrg_pkg::spsrg_src_type srcDecode(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b01: srcDecode = spsrg_pkg::SRC_INT;
			2'b10: srcDecode = spsrg_pkg::SRC_RXPIN;
			2'b11: srcDecode = spsrg_pkg::SRC_TXPIN;
			default: srcDecode = spsrg_pkg::SRC_NONE;
		endcase
	endfunction : srcDecode

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: rx clock, tx clock, rx sync, tx sync

	spsrg_sync_if syncBus[4] ();
	logic [3:0] pinRaw;

	assign pinRaw = {txFrameSyncPinIn, rxFrameSyncPinIn, txClockPinIn, rxClockPinIn};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_sync
			assign syncBus[i].raw = pinRaw[i];
			spsrg_pin_sync u_sync (
				.clock(clock),
				.reset_n(reset_n),
				.port(syncBus[i])
			);
		end
	endgenerate

	logic rxPinRise;
	logic rxPinFall;
	logic rxPinLevel;
	logic txPinRise;
	logic txPinFall;
	logic txPinLevel;
	logic rxSyncLevel;
	logic txSyncLevel;

	assign rxPinRise = syncBus[0].rise;
	assign rxPinFall = syncBus[0].fall;
	assign rxPinLevel = syncBus[0].level;
	assign txPinRise = syncBus[1].rise;
	assign txPinFall = syncBus[1].fall;
	assign txPinLevel = syncBus[1].level;
	assign rxSyncLevel = syncBus[2].level;
	assign txSyncLevel = syncBus[3].level;

	////////////////////////////////////////////////////////////////////////////
	// register file over APB

	logic [`SPSRG_CTRL_W-1:0] ctrl_q;
	logic [`SPSRG_CTRL_W-1:0] ctrl_d;
	logic [`SPSRG_PIN_W-1:0] pin_q;
	logic [`SPSRG_PIN_W-1:0] pin_d;
	logic [15:0] gen1_q;
	logic [15:0] gen1_d;
	logic [15:0] gen2_q;
	logic [15:0] gen2_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [31:0] statusWord;
	logic wrEn;

	assign wrEn = psel & penable & pwrite;

	always_comb begin
		ctrl_d = ctrl_q;
		pin_d = pin_q;
		gen1_d = gen1_q;
		gen2_d = gen2_q;
		prdata_d = prdata_q;
		if (wrEn) begin
			unique case (paddr)
				`SPSRG_OFS_CTRL: ctrl_d = pwdata[`SPSRG_CTRL_W-1:0];
				`SPSRG_OFS_PIN: pin_d = pwdata[`SPSRG_PIN_W-1:0];
				`SPSRG_OFS_GEN1: gen1_d = pwdata[15:0];
				`SPSRG_OFS_GEN2: gen2_d = pwdata[15:0];
				default: ;
			endcase
		end
		// read data is fetched in the setup cycle, so the access needs no wait
		if (psel && !penable) begin
			unique case (paddr)
				`SPSRG_OFS_CTRL: prdata_d = {27'h0, ctrl_q};
				`SPSRG_OFS_PIN: prdata_d = {20'h0, pin_q};
				`SPSRG_OFS_GEN1: prdata_d = {16'h0, gen1_q};
				`SPSRG_OFS_GEN2: prdata_d = {16'h0, gen2_q};
				`SPSRG_OFS_STAT: prdata_d = statusWord;
				default: prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `SPSRG_CTRL_RESET;
			pin_q <= `SPSRG_PIN_RESET;
			gen1_q <= `SPSRG_GEN1_RESET;
			gen2_q <= `SPSRG_GEN2_RESET;
			prdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			pin_q <= pin_d;
			gen1_q <= gen1_d;
			gen2_q <= gen2_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);

	// field views
	logic genRun;
	logic frmRun;
	logic loopSel;
	logic [1:0] stopSel;
	logic rxPol;
	logic txPol;
	logic rxDir;
	logic txDir;
	logic rxFsrc;
	logic txFsrc;
	spsrg_pkg::spsrg_byte_type divVal;
	spsrg_pkg::spsrg_byte_type widVal;
	logic [11:0] perVal;
	logic fgSel;
	logic resyncOn;
	spsrg_pkg::spsrg_src_type src;

	assign genRun = ctrl_q[`SPSRG_CTRL_GEN_RUN];
	assign frmRun = ctrl_q[`SPSRG_CTRL_FRM_RUN];
	assign loopSel = ctrl_q[`SPSRG_CTRL_LOOP];
	assign stopSel = ctrl_q[`SPSRG_CTRL_STOP_HI:`SPSRG_CTRL_STOP_LO];
	assign rxPol = pin_q[`SPSRG_PIN_RX_POL];
	assign txPol = pin_q[`SPSRG_PIN_TX_POL];
	assign rxDir = pin_q[`SPSRG_PIN_RX_DIR];
	assign txDir = pin_q[`SPSRG_PIN_TX_DIR];
	assign rxFsrc = pin_q[`SPSRG_PIN_RX_FSRC];
	assign txFsrc = pin_q[`SPSRG_PIN_TX_FSRC];
	assign divVal = gen1_q[`SPSRG_GEN1_DIV_HI:`SPSRG_GEN1_DIV_LO];
	assign widVal = gen1_q[`SPSRG_GEN1_WID_HI:`SPSRG_GEN1_WID_LO];
	assign perVal = gen2_q[`SPSRG_GEN2_PER_HI:`SPSRG_GEN2_PER_LO];
	assign fgSel = gen2_q[`SPSRG_GEN2_FGSEL];
	assign resyncOn = gen2_q[`SPSRG_GEN2_RESYNC];
	assign src = srcDecode(pin_q[`SPSRG_PIN_SRC_HIGH], gen2_q[`SPSRG_GEN2_SRC_LOW]);

	////////////////////////////////////////////////////////////////////////////
	// source clock edge and external sync detection

	logic srcTick;
	logic extSrc;
	logic rxSyncPrev_q;
	logic rxSyncPrev_d;
	logic resyncEvt;
	logic divRestart;

	always_comb begin
		unique case (src)
			spsrg_pkg::SRC_INT: srcTick = 1'b1;
			spsrg_pkg::SRC_RXPIN: srcTick = rxPol ? rxPinRise : rxPinFall;
			spsrg_pkg::SRC_TXPIN: srcTick = txPol ? txPinFall : txPinRise;
			spsrg_pkg::SRC_NONE: srcTick = 1'b0;
		endcase
	end

	assign extSrc = (src == spsrg_pkg::SRC_RXPIN) || (src == spsrg_pkg::SRC_TXPIN);
	// sampled only on source edges, so a long sync pulse counts once
	assign rxSyncPrev_d = srcTick ? rxSyncLevel : rxSyncPrev_q;
	assign resyncEvt = srcTick & resyncOn & extSrc & rxSyncLevel & ~rxSyncPrev_q;
	assign divRestart = resyncEvt & (src == spsrg_pkg::SRC_RXPIN);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rxSyncPrev_q <= 1'b0;
		end else begin
			rxSyncPrev_q <= rxSyncPrev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bit clock divider

	spsrg_pkg::spsrg_gen_state_type genState_q;
	spsrg_pkg::spsrg_gen_state_type genState_d;
	spsrg_pkg::spsrg_byte_type cnt_q;
	spsrg_pkg::spsrg_byte_type cnt_d;
	spsrg_pkg::spsrg_byte_type hiLast;
	spsrg_pkg::spsrg_byte_type loLast;
	logic bitRise;

	// high p+1 and low p for an even value, equal halves for an odd one
	assign hiLast = {1'b0, divVal[7:1]};
	assign loLast = (divVal == 8'h00) ? 8'h00 : divVal - hiLast - 8'h01;

	always_comb begin
		genState_d = genState_q;
		cnt_d = cnt_q;
		bitRise = 1'b0;
		if (!genRun) begin
			genState_d = spsrg_pkg::GEN_HOLD;
			cnt_d = 8'h00;
		end else if (srcTick) begin
			if (divRestart || genState_q == spsrg_pkg::GEN_HOLD) begin
				genState_d = spsrg_pkg::GEN_HIGH;
				cnt_d = hiLast;
				bitRise = (genState_q != spsrg_pkg::GEN_HIGH);
			end else if (cnt_q != 8'h00) begin
				cnt_d = cnt_q - 8'h01;
			end else if (genState_q == spsrg_pkg::GEN_HIGH) begin
				genState_d = spsrg_pkg::GEN_LOW;
				cnt_d = loLast;
			end else begin
				genState_d = spsrg_pkg::GEN_HIGH;
				cnt_d = hiLast;
				bitRise = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			genState_q <= spsrg_pkg::GEN_HOLD;
			cnt_q <= 8'h00;
		end else begin
			genState_q <= genState_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame pulse: period and width counted in bit clock cycles

	logic [11:0] perCnt_q;
	logic [11:0] perCnt_d;
	spsrg_pkg::spsrg_byte_type widCnt_q;
	spsrg_pkg::spsrg_byte_type widCnt_d;
	logic frame_q;
	logic frame_d;
	logic extFrame;
	logic frameStart;

	assign extFrame = resyncOn & extSrc;
	assign frameStart = extFrame ? resyncEvt
		: (bitRise & (perCnt_q == 12'h000));

	always_comb begin
		perCnt_d = perCnt_q;
		widCnt_d = widCnt_q;
		frame_d = frame_q;
		if (!genRun || !frmRun) begin
			frame_d = 1'b0;
			perCnt_d = perVal;
			widCnt_d = 8'h00;
		end else if (frameStart) begin
			frame_d = 1'b1;
			widCnt_d = widVal;
			perCnt_d = perVal;
		end else if (bitRise) begin
			if (!extFrame) begin
				perCnt_d = perCnt_q - 12'h001;
			end
			if (frame_q && widCnt_q == 8'h00) begin
				frame_d = 1'b0;
			end else if (frame_q) begin
				widCnt_d = widCnt_q - 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			perCnt_q <= 12'h000;
			widCnt_q <= 8'h00;
			frame_q <= 1'b0;
		end else begin
			perCnt_q <= perCnt_d;
			widCnt_q <= widCnt_d;
			frame_q <= frame_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin and internal clock / frame steering, registered outputs

	logic bitClk;
	logic spiMode;
	logic txInt;
	logic [8:0] out_q;
	logic [8:0] out_d;

	assign bitClk = (genState_q == spsrg_pkg::GEN_HIGH);
	assign spiMode = txDir & stopSel[1];
	assign txInt = txDir ? bitClk : txPinLevel;

	always_comb begin
		out_d[0] = bitClk;
		out_d[1] = frame_q;
		out_d[2] = loopSel ? txInt : bitClk;
		out_d[3] = bitClk;
		out_d[4] = txInt;
		if (spiMode) begin
			out_d[5] = txInt;
		end else if (rxDir) begin
			out_d[5] = loopSel ? txInt : bitClk;
		end else begin
			out_d[5] = rxPinLevel;
		end
		out_d[6] = rxFsrc ? frame_q : rxSyncLevel;
		if (!txFsrc) begin
			out_d[7] = txSyncLevel;
		end else begin
			out_d[7] = fgSel ? frame_q : txCopyStrobe;
		end
		out_d[8] = spiMode;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_q <= 9'h000;
		end else begin
			out_q <= out_d;
		end
	end

	assign genBitClock = out_q[0];
	assign genFramePulse = out_q[1];
	assign rxClockPinOut = out_q[2];
	assign rxClockPinOe = rxDir;
	assign txClockPinOut = out_q[3];
	assign txClockPinOe = txDir;
	assign txClockInternal = out_q[4];
	assign rxClockInternal = out_q[5];
	assign rxFrameInternal = out_q[6];
	assign txFrameInternal = out_q[7];
	assign txFrameSyncPinOut = out_q[7];
	assign txFrameSyncPinOe = txFsrc;
	assign spiMaster = out_q[8];

	// status: live generator state for software
	assign statusWord = {27'h0, spiMode, src, frame_q, bitClk};
endmodule : spsrg_top

// File: spsrg_top_sva.sv
// assertions on the sample rate generator top-level ports
`timescale 1ns/10ps
`include "spsrg_defines.svh"
module spsrg_top_sva (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SPSRG_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic rxClockPinOe,
	input wire logic txClockPinOe,
	input wire logic txFrameSyncPinOe,
	input wire logic genBitClock,
	input wire logic genFramePulse,
	input wire logic spiMaster
);
	logic [15:0] ctrl_q, pin_q, g1_q, g2_q;
	logic bcSeen_q, fsSeen_q, intSrc, spi;
	int bcHi_q, bcPrd_q, fsHi_q, fsPrd_q, hold_q;
	// widths judged on the internal source only: there every cycle is a tick
	assign intSrc = !pin_q[7] && g2_q[13] && !g2_q[15] && ctrl_q[0];
	assign spi = pin_q[9] && ctrl_q[4];
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= 16'h0000;
			pin_q <= 16'h0000;
			g1_q <= 16'h0001;
			g2_q <= 16'h2000;
		end else if (psel && penable && pwrite && pready) begin
			case (paddr)
				8'h00: ctrl_q <= pwdata[15:0];
				8'h04: pin_q <= pwdata[15:0];
				8'h08: g1_q <= pwdata[15:0];
				8'h0C: g2_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bcHi_q <= 0;
			bcPrd_q <= 0;
			bcSeen_q <= 1'h0;
			fsHi_q <= 0;
			fsPrd_q <= 0;
			fsSeen_q <= 1'h0;
			hold_q <= 0;
		end else begin
			bcHi_q <= genBitClock ? bcHi_q + 1 : 0;
			bcPrd_q <= $rose(genBitClock) ? 1 : bcPrd_q + 1;
			bcSeen_q <= intSrc && (bcSeen_q || $rose(genBitClock));
			fsHi_q <= genFramePulse ? fsHi_q + 1 : 0;
			fsPrd_q <= $rose(genFramePulse) ? 1 : fsPrd_q + 1;
			fsSeen_q <= intSrc && ctrl_q[1] && (fsSeen_q || $rose(genFramePulse));
			hold_q <= ctrl_q[0] ? 0 : (hold_q < 3 ? hold_q + 1 : 3);
		end
	end
	////////////////////////////////////////////////////////////////
	a_bc_high: assert property ($fell(genBitClock) && bcSeen_q && intSrc |->
		bcHi_q == g1_q[7:0] / 2 + 1) else $error("bit clock high time wrong");
	a_bc_period: assert property ($rose(genBitClock) && bcSeen_q && intSrc |->
		bcPrd_q == g1_q[7:0] + 1) else $error("bit clock period wrong");
	a_fs_width: assert property ($fell(genFramePulse) && fsSeen_q && ctrl_q[1] |->
		fsHi_q == (g1_q[15:8] + 1) * (g1_q[7:0] + 1)) else $error("frame width wrong");
	a_fs_period: assert property ($rose(genFramePulse) && fsSeen_q && ctrl_q[1] |->
		fsPrd_q == (g2_q[11:0] + 1) * (g1_q[7:0] + 1)) else $error("frame period wrong");
	a_held_low: assert property (hold_q == 3 |-> !genBitClock && !genFramePulse)
		else $error("held generator not low");
	a_start_high: assert property ($rose(ctrl_q[0]) && intSrc |-> ##[1:4] genBitClock)
		else $error("bit clock did not start");
	a_rx_dir: assert property ($stable(pin_q[8]) |-> rxClockPinOe == pin_q[8])
		else $error("rx clock pin enable wrong");
	a_tx_dir: assert property ($stable(pin_q[9]) |-> txClockPinOe == pin_q[9])
		else $error("tx clock pin enable wrong");
	a_tx_fs_dir: assert property ($stable(pin_q[11]) |-> txFrameSyncPinOe == pin_q[11])
		else $error("tx frame pin enable wrong");
	a_spi_mode: assert property ($stable(spi) |-> spiMaster == spi)
		else $error("spi master flag wrong");
endmodule : spsrg_top_sva
bind spsrg_top spsrg_top_sva u_sva (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .rxClockPinOe, .txClockPinOe, .txFrameSyncPinOe, .genBitClock,
	.genFramePulse, .spiMaster);

// File: spsrg_ext_model.sv
// external clock source and external frame-sync device
`timescale 1ns/10ps
module spsrg_ext_model #(
	parameter int HALF = 8
) (
	input wire logic clock,
	input wire logic run,
	input wire logic syncReq,
	output logic extClk,
	output logic extSync
);
	int cnt = 0;
	int syncCnt = 0;
	initial begin
		extClk = 1'h0;
		extSync = 1'h0;
	end
	// clock stands still while not running; sync lasts two clock periods
	always @(posedge clock) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			extClk <= (cnt == HALF - 1) ? !extClk : extClk;
		end
		syncCnt <= syncReq ? 4 * HALF : (syncCnt > 0 ? syncCnt - 1 : 0);
		extSync <= syncReq || syncCnt > 1;
	end
endmodule : spsrg_ext_model

// File: tb_serial_port_sample_rate_generator.sv
// self-checking bench for the sample rate generator
`timescale 1ns/10ps
module tb_serial_port_sample_rate_generator;
	localparam int TICK = 16;
	logic clock, reset_n, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic rxClockPinIn, rxClockPinOut, rxClockPinOe, txClockPinIn, txClockPinOut, txClockPinOe;
	logic rxFrameSyncPinIn, txFrameSyncPinIn, txFrameSyncPinOut, txFrameSyncPinOe, txCopyStrobe;
	logic genBitClock, genFramePulse, rxClockInternal, txClockInternal;
	logic rxFrameInternal, txFrameInternal, spiMaster, extRun, syncReq, extClk;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	int h, l, n;
	int divs[4] = '{1, 2, 4, 255};
	logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h1, 32'h2000, 32'h4};
	logic [15:0] pol[4] = '{16'h0, 16'h1, 16'h0, 16'h2};
	logic ph[4] = '{1'h0, 1'h1, 1'h1, 1'h0};
	assign rxClockPinIn = rxClockPinOe ? rxClockPinOut : extClk;
	assign txClockPinIn = txClockPinOe ? txClockPinOut : extClk;
	spsrg_top u_dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxClockPinIn, .rxClockPinOut, .rxClockPinOe, .txClockPinIn,
		.txClockPinOut, .txClockPinOe, .rxFrameSyncPinIn, .txFrameSyncPinIn,
		.txFrameSyncPinOut, .txFrameSyncPinOe, .txCopyStrobe, .genBitClock, .genFramePulse,
		.rxClockInternal, .txClockInternal, .rxFrameInternal, .txFrameInternal, .spiMaster);
	spsrg_ext_model #(.HALF(TICK / 2)) u_ext (.clock, .run(extRun), .syncReq, .extClk,
		.extSync(rxFrameSyncPinIn));
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task end_of_test;
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one idle cycle after each transfer keeps psel from being driven twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : apb
	task setup(input logic [15:0] pin, input logic [15:0] g1, input logic [15:0] g2);
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h04, {16'h0, pin});
		apb(1'h1, 8'h08, {16'h0, g1});
		apb(1'h1, 8'h0C, {16'h0, g2});
		apb(1'h1, 8'h00, 32'h3);
	endtask : setup
	function automatic logic pick(input int s);
		case (s)
			0: pick = genBitClock;
			1: pick = genFramePulse;
			2: pick = txFrameInternal;
			4: pick = txClockPinOut;
			5: pick = rxClockInternal;
			6: pick = txClockInternal;
			7: pick = rxFrameInternal;
			8: pick = txFrameSyncPinOut;
			default: pick = rxClockPinOut;
		endcase
	endfunction : pick
	task span(input int s, input logic v, output int c);
		c = 0;
		while (pick(s) === v && c < 4000) begin
			@(posedge clock);
			c++;
		end
	endtask : span
	task period(input int s, output int hi, output int lo);
		span(s, 1'h1, hi);
		span(s, 1'h0, hi);
		span(s, 1'h1, hi);
		span(s, 1'h0, lo);
	endtask : period
	////////////////////////////////////////////////////////////////
	initial begin
		reset_n = 1'h0;
		{psel, penable, pwrite, txCopyStrobe, txFrameSyncPinIn, extRun, syncReq} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge clock);
		reset_n <= 1'h1;
		@(posedge clock);
		for (int a = 0; a < 5; a++) begin
			apb(1'h0, 8'(a * 4), 32'h0);
			chk(q, rv[a]);
		end
		apb(1'h1, 8'h10, 32'h1F);
		apb(1'h0, 8'h14, 32'h0);
		chk({q[30:0], e}, 32'h1);
		foreach (divs[i]) begin
			setup(16'h0, {8'h01, 8'(divs[i])}, 16'h2003);
			period(0, h, l);
			chk(h, divs[i] / 2 + 1);
			chk(h + l, divs[i] + 1);
			period(4, h, l);
			chk(h + l, divs[i] + 1);
			period(1, h, l);
			chk(h, 2 * (divs[i] + 1));
			chk(h + l, 4 * (divs[i] + 1));
		end
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h04, 32'hB00);
		apb(1'h1, 8'h00, 32'h10);
		apb(1'h0, 8'h10, 32'h0);
		chk(q, 32'h14);
		chk({rxClockPinOe, txClockPinOe, txFrameSyncPinOe, spiMaster}, 32'hF);
		extRun <= 1'h1;
		setup(16'h100, 16'h0001, 16'h2003);
		period(3, h, l);
		chk(h + l, 2);
		period(5, h, l);
		chk(h + l, 2);
		apb(1'h1, 8'h00, 32'h7);
		// loopback: rx clock follows the tx pin, one external period
		period(3, h, l);
		chk(h + l, TICK);
		period(5, h, l);
		chk(h + l, TICK);
		period(6, h, l);
		chk(h + l, TICK);
		setup(16'hC00, 16'h0001, 16'h2003);
		txCopyStrobe <= 1'h1;
		@(posedge clock);
		txCopyStrobe <= 1'h0;
		span(2, 1'h0, n);
		chk(n < 4, 1);
		apb(1'h1, 8'h0C, 32'h3003);
		period(2, h, l);
		chk(h + l, 8);
		period(7, h, l);
		chk(h + l, 8);
		period(8, h, l);
		chk(h + l, 8);
		for (int k = 0; k < 4; k++) begin
			setup(16'h80 | pol[k], 16'h0001, k < 2 ? 16'h0003 : 16'h2003);
			period(0, h, l);
			chk(extClk, ph[k]);
			chk(h, TICK);
			chk(l, TICK);
			apb(1'h0, 8'h10, 32'h0);
			chk(q[3:2], k < 2 ? 2 : 3);
		end
		setup(16'h80, 16'h0001, 16'h8FFF);
		for (int k = 0; k < 2; k++) begin
			syncReq <= 1'h1;
			@(posedge clock);
			syncReq <= 1'h0;
			span(7, 1'h0, n);
			chk(n < 8, 1);
			span(1, 1'h0, n);
			chk(n < 64, 1);
			span(1, 1'h1, h);
			chk(h, 2 * TICK);
		end
		span(1, 1'h0, n);
		chk(n, 4000);
		end_of_test();
	end
endmodule : tb_serial_port_sample_rate_generator
